// ### hw/byte_op_defs.svh
`ifndef BYTE_OP_DEFS_SVH
`define BYTE_OP_DEFS_SVH
// Register byte offsets
`define REG_INSTR 10'h000
`define REG_ACC 10'h004
`define REG_STATUS 10'h008
`define REG_TIMER_CTRL 10'h00C
`define FILE_WINDOW_BIT 9
// Instruction word fields
`define CLASS_MSB 13
`define CLASS_LSB 12
`define OP_MSB 11
`define OP_LSB 8
`define DEST_BIT 7
`define FSEL_MSB 6
`define BOP_MSB 11
`define BOP_LSB 10
`define BSEL_MSB 9
`define BSEL_LSB 7
`define CLASS_BYTE 2'h0
`define CLASS_BIT 2'h1
// Byte operation codes
`define OP_STORE 4'h0
`define OP_CLEAR 4'h1
`define OP_SUB 4'h2
`define OP_DEC 4'h3
`define OP_OR 4'h4
`define OP_AND 4'h5
`define OP_XOR 4'h6
`define OP_ADD 4'h7
`define OP_MOVE 4'h8
`define OP_COMP 4'h9
`define OP_INC 4'hA
`define OP_DECSKIP 4'hB
`define OP_RR 4'hC
`define OP_RL 4'hD
`define OP_SWAP 4'hE
`define OP_INCSKIP 4'hF
`define FSEL_CLEAR_ACC 7'h03
// Bit operation codes
`define BOP_CLR 2'h0
`define BOP_SET 2'h1
`define BOP_TST_CLR 2'h2
`define BOP_TST_SET 2'h3
// Status and timer control bits
`define ST_C_BIT 0
`define ST_DC_BIT 1
`define ST_Z_BIT 2
`define ST_PD_BIT 3
`define ST_TO_BIT 4
`define TCTRL_ASSIGN_BIT 0
`define TCTRL_RATE_MSB 3
`define TCTRL_RATE_LSB 1
// Special file addresses
`define FILE_TIMER_ADDR 7'h01
`define FILE_PORT_ADDR 7'h06
`define FILE_WORDS 128
// Reset values
`define RST_INSTR 14'h0000
`define RST_BYTE 8'h00
`define RST_TCTRL 4'h0
`define RST_FLAG 1'b0
`define RST_TO 1'b1
`define RST_PD 1'b1
// Timing: oscillator periods per instruction cycle
`define QUAD_CLKS 3'h4
`define QUAD_LAST (`QUAD_CLKS - 3'h1)
`define TWO_LAST (`QUAD_CLKS + `QUAD_LAST)
`endif

// ### hw/byte_op_pkg.sv
package byte_op_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [13:0] instr_t;
	typedef logic [6:0] file_addr_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RESP} bus_state_e;
endpackage : byte_op_pkg

// ### hw/alu_if.sv
`timescale 1ns/100ps
interface alu_if;
	byte_op_pkg::instr_t instr;
	byte_op_pkg::byte_t acc;
	byte_op_pkg::byte_t operand;
	logic carry;
	byte_op_pkg::byte_t result;
	logic wr_acc;
	logic wr_file;
	logic upd_c;
	logic upd_dc;
	logic upd_z;
	logic new_c;
	logic new_dc;
	logic new_z;
	logic two_cycle;
	modport core (output instr, acc, operand, carry,
		input result, wr_acc, wr_file, upd_c, upd_dc, upd_z, new_c, new_dc, new_z, two_cycle);
	modport alu (input instr, acc, operand, carry,
		output result, wr_acc, wr_file, upd_c, upd_dc, upd_z, new_c, new_dc, new_z, two_cycle);
endinterface : alu_if

// ### hw/byte_alu.sv
`timescale 1ns/100ps
`include "byte_op_defs.svh"
module byte_alu (
	alu_if.alu io
);
	// Field split of the instruction word
	wire [1:0] op_class = io.instr[`CLASS_MSB:`CLASS_LSB]; // RULE1 RULE6
	wire [3:0] opcode = io.instr[`OP_MSB:`OP_LSB]; // RULE6
	wire dest = io.instr[`DEST_BIT]; // RULE2
	wire [6:0] fsel = io.instr[`FSEL_MSB:0]; // RULE3
	wire [1:0] bop = io.instr[`BOP_MSB:`BOP_LSB];
	wire [2:0] bsel = io.instr[`BSEL_MSB:`BSEL_LSB]; // RULE14
	wire [7:0] bit_mask = 8'h01 << bsel; // RULE14

	// Arithmetic with carry and nibble carry
	wire [8:0] add_sum = {1'b0, io.acc} + {1'b0, io.operand};
	wire [4:0] add_nib = {1'b0, io.acc[3:0]} + {1'b0, io.operand[3:0]};
	wire [8:0] sub_sum = {1'b0, io.operand} + {1'b0, ~io.acc} + 9'h001;
	wire [4:0] sub_nib = {1'b0, io.operand[3:0]} + {1'b0, ~io.acc[3:0]} + 5'h01;
	wire [7:0] dec_val = io.operand - 8'h01;
	wire [7:0] inc_val = io.operand + 8'h01;

	logic [7:0] res;
	logic to_dest;
	logic wf;
	logic wa;

	// Decode and result selection
	always_comb
	begin
		res = io.operand;
		to_dest = 1'b0;
		wf = 1'b0;
		wa = 1'b0;
		io.upd_c = 1'b0;
		io.upd_dc = 1'b0;
		io.upd_z = 1'b0;
		io.new_c = io.carry;
		io.new_dc = 1'b0;
		io.two_cycle = 1'b0;
		if (op_class == `CLASS_BYTE) // RULE6
		begin
			case (opcode)
				`OP_ADD:
				begin
					res = add_sum[7:0]; // RULE7
					io.new_c = add_sum[8];
					io.new_dc = add_nib[4];
					{io.upd_c, io.upd_dc, io.upd_z, to_dest} = 4'hF; // RULE7
				end
				`OP_SUB:
				begin
					res = sub_sum[7:0]; // RULE7
					io.new_c = sub_sum[8];
					io.new_dc = sub_nib[4];
					{io.upd_c, io.upd_dc, io.upd_z, to_dest} = 4'hF; // RULE7
				end
				`OP_AND: {res, io.upd_z, to_dest} = {io.acc & io.operand, 2'h3}; // RULE8
				`OP_OR: {res, io.upd_z, to_dest} = {io.acc | io.operand, 2'h3}; // RULE8
				`OP_XOR: {res, io.upd_z, to_dest} = {io.acc ^ io.operand, 2'h3}; // RULE9
				`OP_COMP: {res, io.upd_z, to_dest} = {~io.operand, 2'h3}; // RULE9
				`OP_DEC: {res, io.upd_z, to_dest} = {dec_val, 2'h3}; // RULE10
				`OP_INC: {res, io.upd_z, to_dest} = {inc_val, 2'h3}; // RULE11
				`OP_DECSKIP:
				begin
					{res, to_dest} = {dec_val, 1'b1}; // RULE10
					io.two_cycle = (dec_val == 8'h00); // RULE10 RULE4
				end
				`OP_INCSKIP:
				begin
					{res, to_dest} = {inc_val, 1'b1}; // RULE11
					io.two_cycle = (inc_val == 8'h00); // RULE11 RULE4
				end
				`OP_RL:
				begin
					{res, to_dest} = {io.operand[6:0], io.carry, 1'b1}; // RULE12
					{io.new_c, io.upd_c} = {io.operand[7], 1'b1}; // RULE12
				end
				`OP_RR:
				begin
					{res, to_dest} = {io.carry, io.operand[7:1], 1'b1}; // RULE13
					{io.new_c, io.upd_c} = {io.operand[0], 1'b1}; // RULE13
				end
				`OP_MOVE: {io.upd_z, to_dest} = 2'h3; // RULE18
				`OP_SWAP: {res, to_dest} = {io.operand[3:0], io.operand[7:4], 1'b1}; // RULE18
				`OP_CLEAR:
				begin
					res = 8'h00;
					io.upd_z = dest | (fsel == `FSEL_CLEAR_ACC); // RULE18
					wf = dest; // RULE18
					wa = ~dest & (fsel == `FSEL_CLEAR_ACC); // RULE18
				end
				`OP_STORE:
				begin
					res = io.acc; // RULE18
					wf = dest; // Destination zero with any low bits is a no-op RULE15 RULE18
				end
				default: res = io.operand;
			endcase
		end
		else if (op_class == `CLASS_BIT)
		begin
			case (bop)
				`BOP_CLR: {res, wf} = {io.operand & ~bit_mask, 1'b1}; // RULE14
				`BOP_SET: {res, wf} = {io.operand | bit_mask, 1'b1}; // RULE14
				`BOP_TST_CLR: io.two_cycle = ((io.operand & bit_mask) == 8'h00); // RULE14 RULE4
				`BOP_TST_SET: io.two_cycle = ((io.operand & bit_mask) != 8'h00); // RULE14 RULE4
				default: res = io.operand;
			endcase
		end
	end

	// Destination steering
	assign io.result = res;
	assign io.wr_file = wf | (to_dest & dest); // RULE2
	assign io.wr_acc = wa | (to_dest & ~dest); // RULE2
	assign io.new_z = (res == 8'h00);
endmodule : byte_alu

// ### hw/byte_op_instruction_decoder.sv
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "byte_op_defs.svh"
// Contract
// RULE1 - Instructions are single fourteen-bit words
// RULE2 - Destination zero accumulator, one file register
// RULE3 - Seven-bit address selects one file register
// RULE4 - One cycle; skips take a second idle
// RULE5 - Instruction cycle is four oscillator periods
// RULE6 - Top bits zero mark byte operations
// RULE7 - Add and subtract update carry, half-carry, zero
// RULE8 - AND and OR update zero only
// RULE9 - XOR and complement update zero only
// RULE10 - Decrement sets zero; skip variant keeps flags
// RULE11 - Increment sets zero; skip variant keeps flags
// RULE12 - Rotate left through carry, carry only
// RULE13 - Rotate right through carry, carry only
// RULE14 - Bit select picks one of eight bits
// RULE15 - Don't care bits never change decoding; destination-zero clear writes the accumulator only when fsel is 7'h03
// RULE16 - Port operand comes from pin levels
// RULE17 - Timer write clears assigned prescaler
// RULE18 - Clear, store, move, swap, no-op decoded
module byte_op_instruction_decoder (
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	input wire logic [9:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [7:0] PORT_PIN_I,
	output logic [7:0] PORT_LATCH_O
);
	byte_op_pkg::bus_state_e state_ff;
	byte_op_pkg::bus_state_e nxt_state;
	byte_op_pkg::instr_t instr_ff;
	byte_op_pkg::byte_t acc_ff;
	byte_op_pkg::byte_t file_ff [0:`FILE_WORDS-1];
	byte_op_pkg::byte_t prescaler_ff;
	logic [3:0] tctrl_ff;
	logic [2:0] cnt_ff;
	logic [2:0] quad_ff;
	logic carry_ff;
	logic half_carry_flag_ff;
	logic zero_ff;
	logic timeout_flag_ff;
	logic powerdown_flag_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;

	alu_if alu_bus();

	byte_alu u_alu (
		.io(alu_bus.alu)
	);

	// Bus request decode
	wire req = AVS_READ_I | AVS_WRITE_I;
	wire take = (state_ff == byte_op_pkg::ST_IDLE) & req;
	wire [9:0] word_addr = {AVS_ADDRESS_I[9:2], 2'b00};
	wire hit_file = AVS_ADDRESS_I[`FILE_WINDOW_BIT];
	wire hit_instr = (word_addr == `REG_INSTR);
	wire hit_acc = (word_addr == `REG_ACC);
	wire hit_status = (word_addr == `REG_STATUS);
	wire hit_tctrl = (word_addr == `REG_TIMER_CTRL);
	wire lane0 = AVS_BYTEENABLE_I[0];
	wire bus_wr = take & AVS_WRITE_I;
	wire issue = bus_wr & hit_instr & (AVS_BYTEENABLE_I[1:0] != 2'b00);
	wire bus_file_we = bus_wr & hit_file & lane0;
	wire bus_acc_we = bus_wr & hit_acc & lane0;
	wire bus_status_we = bus_wr & hit_status & lane0;
	wire bus_tctrl_we = bus_wr & hit_tctrl & lane0;
	wire [6:0] bus_faddr = AVS_ADDRESS_I[8:2];

	// Instruction word merged by byte lanes
	wire [13:0] instr_wdata = {AVS_BYTEENABLE_I[1] ? AVS_WRITEDATA_I[13:8] : instr_ff[13:8],
		lane0 ? AVS_WRITEDATA_I[7:0] : instr_ff[7:0]}; // RULE1

	// Execution timing
	wire commit = (state_ff == byte_op_pkg::ST_EXEC) & (cnt_ff == `QUAD_LAST); // RULE5
	wire finish = (state_ff == byte_op_pkg::ST_EXEC)
		& (((cnt_ff == `QUAD_LAST) & ~alu_bus.two_cycle) | (cnt_ff == `TWO_LAST)); // RULE4

	// Operand fetch, port reads see the pins
	wire [6:0] inst_faddr = instr_ff[`FSEL_MSB:0]; // RULE3
	wire [7:0] inst_operand = (inst_faddr == `FILE_PORT_ADDR) ? PORT_PIN_I : file_ff[inst_faddr]; // RULE16
	wire [7:0] bus_file_val = (bus_faddr == `FILE_PORT_ADDR) ? PORT_PIN_I : file_ff[bus_faddr]; // RULE16

	// Arithmetic unit hookup
	assign alu_bus.instr = instr_ff;
	assign alu_bus.acc = acc_ff;
	assign alu_bus.operand = inst_operand;
	assign alu_bus.carry = carry_ff;

	// File write port shared by bus and core
	wire core_file_we = commit & alu_bus.wr_file; // RULE2
	wire file_we = core_file_we | bus_file_we;
	wire [6:0] file_waddr = core_file_we ? inst_faddr : bus_faddr;
	wire [7:0] file_wdata = core_file_we ? alu_bus.result : AVS_WRITEDATA_I[7:0];

	// Timer and prescaler
	wire assigned = tctrl_ff[`TCTRL_ASSIGN_BIT];
	wire [2:0] rate = tctrl_ff[`TCTRL_RATE_MSB:`TCTRL_RATE_LSB];
	wire [7:0] rate_mask = (8'h02 << rate) - 8'h01;
	wire quad_wrap = (quad_ff == `QUAD_LAST); // RULE5
	wire timer_tick = quad_wrap & (~assigned | ((prescaler_ff & rate_mask) == rate_mask));
	wire timer_written = file_we & (file_waddr == `FILE_TIMER_ADDR);
	wire presc_clear = timer_written & assigned; // RULE17

	// Register read mux
	wire [31:0] reg_rdata = hit_file ? {24'h00_0000, bus_file_val}
		: hit_instr ? {18'h0_0000, instr_ff}
		: hit_acc ? {24'h00_0000, acc_ff}
		: hit_status ? {27'h000_0000, timeout_flag_ff, powerdown_flag_ff, zero_ff, half_carry_flag_ff, carry_ff}
		: hit_tctrl ? {28'h000_0000, tctrl_ff}
		: 32'h0000_0000;

	// Next accumulator and flags
	wire [7:0] nxt_acc = (commit & alu_bus.wr_acc) ? alu_bus.result
		: bus_acc_we ? AVS_WRITEDATA_I[7:0] : acc_ff; // RULE2
	wire nxt_carry = (commit & alu_bus.upd_c) ? alu_bus.new_c
		: bus_status_we ? AVS_WRITEDATA_I[`ST_C_BIT] : carry_ff; // RULE7 RULE12 RULE13
	wire nxt_half_carry = (commit & alu_bus.upd_dc) ? alu_bus.new_dc
		: bus_status_we ? AVS_WRITEDATA_I[`ST_DC_BIT] : half_carry_flag_ff; // RULE7
	wire nxt_zero = (commit & alu_bus.upd_z) ? alu_bus.new_z
		: bus_status_we ? AVS_WRITEDATA_I[`ST_Z_BIT] : zero_ff; // RULE8 RULE9 RULE10 RULE11

	// Bus sequencing
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			byte_op_pkg::ST_IDLE:
			begin
				if (issue)
					nxt_state = byte_op_pkg::ST_EXEC;
				else if (take)
					nxt_state = byte_op_pkg::ST_RESP;
			end
			byte_op_pkg::ST_EXEC:
			begin
				if (finish)
					nxt_state = byte_op_pkg::ST_RESP; // RULE4
			end
			byte_op_pkg::ST_RESP: nxt_state = byte_op_pkg::ST_IDLE;
			default: nxt_state = byte_op_pkg::ST_IDLE;
		endcase
	end

	wire nxt_wait = ~((take & ~issue) | finish);
	wire [2:0] nxt_cnt = (state_ff == byte_op_pkg::ST_EXEC) ? cnt_ff + 3'h1 : 3'h0;
	wire [2:0] nxt_quad = quad_wrap ? 3'h0 : quad_ff + 3'h1; // RULE5

	// State, handshake and counters
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_ff <= byte_op_pkg::ST_IDLE;
			wait_ff <= 1'b1;
			cnt_ff <= 3'h0;
			quad_ff <= 3'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			wait_ff <= nxt_wait;
			cnt_ff <= nxt_cnt; // RULE4 RULE5
			quad_ff <= nxt_quad;
		end
	end

	// Read data capture
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			rdata_ff <= 32'h0000_0000;
		else if (take & AVS_READ_I)
			rdata_ff <= reg_rdata;
	end

	// Instruction latch
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			instr_ff <= `RST_INSTR;
		else if (issue)
			instr_ff <= instr_wdata; // RULE1
	end

	// Accumulator and arithmetic flags
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			acc_ff <= `RST_BYTE;
			carry_ff <= `RST_FLAG;
			half_carry_flag_ff <= `RST_FLAG;
			zero_ff <= `RST_FLAG;
		end
		else
		begin
			acc_ff <= nxt_acc;
			carry_ff <= nxt_carry;
			half_carry_flag_ff <= nxt_half_carry;
			zero_ff <= nxt_zero;
		end
	end

	// Timeout and power-down flags hold their power-up state
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			timeout_flag_ff <= `RST_TO;
			powerdown_flag_ff <= `RST_PD;
		end
		else
		begin
			timeout_flag_ff <= timeout_flag_ff;
			powerdown_flag_ff <= powerdown_flag_ff;
		end
	end

	// Timer control register
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			tctrl_ff <= `RST_TCTRL;
		else if (bus_tctrl_we)
			tctrl_ff <= AVS_WRITEDATA_I[3:0];
	end

	// Prescaler; a timer write clears it when assigned
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			prescaler_ff <= `RST_BYTE;
		else if (presc_clear)
			prescaler_ff <= `RST_BYTE; // RULE17
		else if (quad_wrap & assigned)
			prescaler_ff <= prescaler_ff + 8'h01;
	end

	// File registers; writes win over a timer tick
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			for (int i = 0; i < `FILE_WORDS; i++)
				file_ff[i] <= `RST_BYTE;
		end
		else if (file_we)
			file_ff[file_waddr] <= file_wdata; // RULE2 RULE3
		else if (timer_tick)
			file_ff[`FILE_TIMER_ADDR] <= file_ff[`FILE_TIMER_ADDR] + 8'h01;
	end

	// Outputs straight from flops
	assign AVS_READDATA_O = rdata_ff;
	assign AVS_WAITREQUEST_O = wait_ff;
	assign PORT_LATCH_O = file_ff[`FILE_PORT_ADDR];
endmodule : byte_op_instruction_decoder

// ### tb/byte_op_checker.sv
`timescale 1ns/100ps
module byte_op_checker (
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	input wire logic [9:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic [7:0] PORT_LATCH_O
);
	// One clock domain for every check
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);
	// Instruction register select
	wire logic instr_sel = AVS_ADDRESS_I[9:2] == 8'h00;
	// Instruction write request; the rising edge is taken inside each property
	wire logic instr_go = AVS_WRITE_I && instr_sel && (AVS_BYTEENABLE_I[1:0] != 2'h0);

	wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low for more than one cycle");
	answer_cause_a: assert property (!AVS_WAITREQUEST_O |-> AVS_READ_I || AVS_WRITE_I)
		else $error("answer without a request");
	read_fast_a: assert property ($rose(AVS_READ_I) |=> !AVS_WAITREQUEST_O)
		else $error("read not answered after one cycle");
	reg_write_fast_a: assert property ($rose(AVS_WRITE_I) && !instr_sel |=> !AVS_WAITREQUEST_O)
		else $error("register write not answered after one cycle");
	instr_time_a: assert property (($rose(AVS_WRITE_I) && instr_go) |=> AVS_WAITREQUEST_O[*4] ##1
		(!AVS_WAITREQUEST_O or (AVS_WAITREQUEST_O[*4] ##1 !AVS_WAITREQUEST_O))) else $error("instruction time wrong");
	rdata_hold_a: assert property (!$stable(AVS_READDATA_O) |-> AVS_READ_I && !AVS_WAITREQUEST_O)
		else $error("read data changed outside a read answer");
	unmapped_zero_a: assert property ($rose(AVS_READ_I) && !AVS_ADDRESS_I[9] && AVS_ADDRESS_I[8:2] > 7'h03
		|=> AVS_READDATA_O == 32'h0000_0000) else $error("unmapped read not zero");
	instr_width_a: assert property ($rose(AVS_READ_I) && instr_sel |=> AVS_READDATA_O[31:14] == 18'h0_0000)
		else $error("instruction word wider than fourteen bits");
	latch_cause_a: assert property (!$stable(PORT_LATCH_O) |-> AVS_WRITE_I)
		else $error("port latch changed without a write");

	// Main scenarios reached
	read_c: cover property ($rose(AVS_READ_I) ##1 !AVS_WAITREQUEST_O);
	one_cycle_c: cover property (($rose(AVS_WRITE_I) && instr_go) ##5 !AVS_WAITREQUEST_O);
	skip_c: cover property (($rose(AVS_WRITE_I) && instr_go) ##9 !AVS_WAITREQUEST_O);
endmodule : byte_op_checker

bind byte_op_instruction_decoder byte_op_checker byte_op_checker_inst (
	.MCLK_I(MCLK_I),
	.RESETN_I(RESETN_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I),
	.AVS_WRITE_I(AVS_WRITE_I),
	.AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
	.AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.PORT_LATCH_O(PORT_LATCH_O)
);

// ### tb/byte_op_instruction_decoder_tb_top.sv
`timescale 1ns/100ps
module byte_op_instruction_decoder_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] addr = 10'h000;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [7:0] pins = 8'hA5;
	logic [31:0] rdata;
	logic waitreq;
	logic [7:0] latch;
	logic [31:0] rd;
	logic [7:0] tv;
	logic [7:0] av [3] = '{8'h3C, 8'hFF, 8'h00};
	logic [7:0] rv [3] = '{8'hC5, 8'h01, 8'hFF};
	logic [2:0] sv [3] = '{3'h1, 3'h6, 3'h0};
	int n;
	int fails = 0;
	int checked = 0;

	// Free-running 50 MHz clock
	always #10 clk = ~clk;

	// Block under test
	byte_op_instruction_decoder byte_op_instruction_decoder_inst (
		.MCLK_I(clk),
		.RESETN_I(rst_n),
		.AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd_req),
		.AVS_WRITE_I(wr_req),
		.AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(waitreq),
		.PORT_PIN_I(pins),
		.PORT_LATCH_O(latch)
	);

	// Counts and verdict
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// Compare one value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One bus cycle; holds until waitrequest is sampled low, then one idle cycle
	task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		rd_req <= !wr;
		wr_req <= wr;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitreq !== 1'b0 && n < 40);
		rd = rdata;
		if (waitreq !== 1'b0)
		begin
			fails++;
			$display("CHECK FAILED answer expected 0 seen %b", waitreq);
			wrap_up();
		end
		rd_req <= 1'b0;
		wr_req <= 1'b0;
		@(posedge clk);
	endtask : access

	// Read and compare
	task automatic rchk(input string what, input logic [9:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask : rchk

	// Load operands, execute one byte operation, compare timing and results
	task automatic run_op(input logic [3:0] op, input logic d, input logic [6:0] f,
		input logic [7:0] a, input logic [7:0] r, input logic [2:0] st);
		logic [8:0] s;
		logic [7:0] res;
		logic [2:0] fl;
		logic skip;
		logic wb;
		fl = st;
		skip = 1'b0;
		wb = 1'b1;
		res = r;
		case (op)
			4'h0: begin res = a; wb = d; end
			4'h1: begin res = 8'h00; wb = d || f == 7'h03; end
			4'h2: begin s = {1'b0, r} - {1'b0, a}; res = s[7:0]; fl[0] = !s[8]; fl[1] = r[3:0] >= a[3:0]; end
			4'h3: res = r - 8'h01;
			4'h4: res = r | a;
			4'h5: res = r & a;
			4'h6: res = r ^ a;
			4'h7: begin s = r + a; res = s[7:0]; fl[0] = s[8]; fl[1] = (r[3:0] + a[3:0]) > 15; end
			4'h9: res = ~r;
			4'hA: res = r + 8'h01;
			4'hB: begin res = r - 8'h01; skip = res == 8'h00; end
			4'hC: begin res = {st[0], r[7:1]}; fl[0] = r[0]; end
			4'hD: begin res = {r[6:0], st[0]}; fl[0] = r[7]; end
			4'hE: res = {r[3:0], r[7:4]};
			4'hF: begin res = r + 8'h01; skip = res == 8'h00; end
			default: res = r;
		endcase
		if (op >= 4'h1 && op <= 4'hA && wb)
			fl[2] = res == 8'h00;
		access(1'b1, 10'h004, {24'h00_0000, a});
		access(1'b1, {1'b1, f, 2'b00}, {24'h00_0000, r});
		access(1'b1, 10'h008, {29'h0, st});
		access(1'b1, 10'h000, {18'h0_0000, 2'h0, op, d, f});
		chk("cycles", skip ? 32'hA : 32'h6, n);
		rchk("acc", 10'h004, {24'h00_0000, (wb && !d) ? res : a});
		rchk("file", {1'b1, f, 2'b00}, {24'h00_0000, (wb && d) ? res : r});
		rchk("status", 10'h008, {27'h000_0000, 2'b11, fl});
		rchk("instr", 10'h000, {18'h0_0000, 2'h0, op, d, f});
	endtask : run_op

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("waitreq", 32'h1, {31'h0, waitreq});
		chk("latch", 32'h0, {24'h00_0000, latch});
		rchk("status", 10'h008, 32'h18);
		rchk("unmapped", 10'h010, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 3; i++)
			for (int op = 0; op < 16; op++)
				for (int d = 0; d < 2; d++)
					run_op(op[3:0], d[0], {2'b10, op[3:0], d[0]}, av[i], rv[i], sv[i]);
		run_op(4'h1, 1'b0, 7'h03, 8'h77, 8'h12, 3'h0);
		run_op(4'h8, 1'b1, 7'h7F, 8'h12, 8'h80, 3'h7);
		for (int b = 0; b < 8; b++)
		begin
			access(1'b1, 10'h2A0, 32'h0);
			access(1'b1, 10'h000, {18'h0_0000, 2'b01, 2'b01, b[2:0], 7'h28});
			rchk("bit set", 10'h2A0, 32'h1 << b);
		end
		// Bit clear and both bit tests, with and without the skip cycle
		access(1'b1, 10'h2A0, 32'hFF);
		access(1'b1, 10'h000, {18'h0_0000, 2'b01, 2'b00, 3'h3, 7'h28});
		chk("clear cycles", 32'h6, n);
		rchk("bit clear", 10'h2A0, 32'hF7);
		access(1'b1, 10'h000, {18'h0_0000, 2'b01, 2'b10, 3'h3, 7'h28});
		chk("test clear skip", 32'hA, n);
		access(1'b1, 10'h000, {18'h0_0000, 2'b01, 2'b11, 3'h3, 7'h28});
		chk("test set no skip", 32'h6, n);
		access(1'b1, 10'h000, {18'h0_0000, 2'b01, 2'b11, 3'h7, 7'h28});
		chk("test set skip", 32'hA, n);
		access(1'b1, 10'h000, {18'h0_0000, 2'b01, 2'b10, 3'h7, 7'h28});
		chk("test clear no skip", 32'h6, n);
		rchk("bit tests keep file", 10'h2A0, 32'hF7);
		$display("instruction tests done");
		access(1'b1, 10'h218, 32'h5A);
		chk("latch", 32'h5A, {24'h00_0000, latch});
		rchk("pins", 10'h218, 32'hA5);
		access(1'b1, 10'h000, {18'h0_0000, 2'h0, 4'h8, 1'b1, 7'h06});
		chk("latch", 32'hA5, {24'h00_0000, latch});
		pins <= 8'h3C;
		access(1'b1, 10'h000, {18'h0_0000, 2'h0, 4'h9, 1'b1, 7'h06});
		chk("latch", 32'hC3, {24'h00_0000, latch});
		$display("port test done");
		access(1'b1, 10'h00C, 32'h0);
		access(1'b0, 10'h204, 32'h0);
		tv = rd[7:0] + 8'h0A;
		repeat (37) @(posedge clk);
		rchk("timer ticks", 10'h204, {24'h00_0000, tv});
		access(1'b1, 10'h00C, 32'hF);
		repeat (600) @(posedge clk);
		access(1'b1, 10'h204, 32'h0);
		repeat (800) @(posedge clk);
		rchk("timer cleared", 10'h204, 32'h0);
		$display("timer test done");
		wrap_up();
	end
endmodule : byte_op_instruction_decoder_tb_top
